// ### pkg/almd_regs.vh
// Constants for the analog limit monitor: status bit positions, defaults, timing.
// Assumes a 40 MHz system clock; included by bare name from design files.
// What this block does
// - Mask bits 6,7: current two high/low
// - Bit 8: supply below 17 volts
// - Bits 9,10: voltage channels beyond ten volts
// - Bits 11,12: current outside 0/4..20 mA
// - Bits 13,14: live-zero wire break below 2 mA
// - Status word in bytes 9,10, always live
// - Mask gates events only, not status
// - One sample per interval, 1 ms..60 s
// - Filter code 0 none, 1-4 average 4..32
// - Below low: set bit, output 1, event
// - Above high (default 31211): bit, output 2
// - Low clears above low plus hysteresis
// - High clears below high minus hysteresis
// - Reference source codes 0..3 select channel
// - Enable bit gives appear and disappear events
// - Bits 0,1: voltage one high/low
`ifndef ALMD_REGS_VH
`define ALMD_REGS_VH
`define ALMD_B_V1_HIGH 0
`define ALMD_B_V1_LOW 1
`define ALMD_B_V2_HIGH 2
`define ALMD_B_V2_LOW 3
`define ALMD_B_C1_HIGH 4
`define ALMD_B_C1_LOW 5
`define ALMD_B_C2_HIGH 6
`define ALMD_B_C2_LOW 7
`define ALMD_B_UNDERVOLT 8
`define ALMD_B_V1_RANGE 9
`define ALMD_B_V2_RANGE 10
`define ALMD_B_C1_RANGE 11
`define ALMD_B_C2_RANGE 12
`define ALMD_B_C1_BREAK 13
`define ALMD_B_C2_BREAK 14
`define ALMD_MASK_RESET 16'h0000
`define ALMD_MASK_WRITABLE 16'h7FFF
`define ALMD_LOW_DEFAULT 16'h0000
`define ALMD_HIGH_DEFAULT 16'h79EB
`define ALMD_HYST_DEFAULT 16'h000F
`define ALMD_SRC_V1 2'h0
`define ALMD_SRC_V2 2'h1
`define ALMD_SRC_C1 2'h2
`define ALMD_SRC_C2 2'h3
`define ALMD_CLK_HZ 40000000
`define ALMD_INTERVAL_MS_DEFAULT 10
`define ALMD_INTERVAL_MS_MIN 1
`define ALMD_INTERVAL_MS_MAX 60000
`define ALMD_CYC_PER_MS (`ALMD_CLK_HZ / 1000)
`define ALMD_SUPPLY_MIN_MV 17000
`define ALMD_V_RANGE_MV 10000
`define ALMD_C_MAX_UA 20000
`define ALMD_C_LIVE_ZERO_UA 4000
`define ALMD_C_BREAK_UA 2000
`endif

// ### hdl/almd_hist.v
// Sample history memory for the moving average, 32 words deep.
// Assumes one write per sample; read data registered, one cycle latency.
`timescale 1ns/10ps
module almd_hist #(
	parameter WIDTH = 16,
	parameter DEPTH_LOG2 = 5
) (
	input wire clk,
	input wire wr_en,
	input wire [DEPTH_LOG2-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	input wire [DEPTH_LOG2-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // almd_hist

// ### hdl/almd_top.v
// Limit monitor for one channel, voltage or current, picked by CHANNEL_ID, plus the shared condition word and event mask.
// Assumes sample and measurement inputs synchronous to CLK_SYS; the link side
// reads STATUS_WORD and takes EVENT_* pulses.
`timescale 1ns/10ps
`include "almd_regs.vh"
module almd_top #(
	parameter WIDTH = 16,
	parameter CYC_PER_MS = `ALMD_CYC_PER_MS
) (
	input wire CLK_SYS,
	input wire RESETN,
	input wire signed [WIDTH-1:0] SAMPLE_VALUE,
	input wire [15:0] INTERVAL_MS,
	input wire [2:0] FILTER_SEL,
	input wire signed [15:0] LOW_LIMIT,
	input wire signed [15:0] HIGH_LIMIT,
	input wire [14:0] LOW_RELEASE_MARGIN,
	input wire [14:0] HIGH_RELEASE_MARGIN,
	input wire [1:0] REF_SOURCE,
	input wire [1:0] CHANNEL_ID,
	input wire [1:0] LIVE_ZERO_CFG,
	input wire [15:0] SUPPLY_MV,
	input wire signed [15:0] VOLT_ONE_MV,
	input wire signed [15:0] VOLT_TWO_MV,
	input wire signed [15:0] CURR_ONE_UA,
	input wire signed [15:0] CURR_TWO_UA,
	input wire [7:0] OTHER_LIMIT_BITS,
	input wire MASK_WR,
	input wire [15:0] MASK_WDATA,
	output reg [15:0] EVENT_MASK,
	output reg [15:0] STATUS_WORD,
	output reg [7:0] PD_BYTE9,
	output reg [7:0] PD_BYTE10,
	output reg SWITCH_OUT1,
	output reg SWITCH_OUT2,
	output reg EVENT_APPEAR,
	output reg EVENT_DISAPPEAR,
	output reg [15:0] EVENT_BITS,
	output reg SAMPLE_DONE
);
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_EVAL = 2'b10;
	localparam ST_DONE = 2'b11;

	reg [1:0] state;
	reg [31:0] tick_count;
	reg [15:0] ms_count;
	reg [4:0] wr_ptr;
	reg [5:0] fill_count;
	reg signed [WIDTH+5:0] acc;
	reg signed [WIDTH-1:0] held_sample;
	reg signed [WIDTH-1:0] eval_value;
	reg low_state;
	reg high_state;
	reg [15:0] prev_status;
	reg [15:0] next_status;
	wire [WIDTH-1:0] old_sample;
	wire [15:0] interval;
	wire ms_tick;
	wire [5:0] win_len;
	wire [4:0] old_addr;
	wire signed [WIDTH+5:0] next_acc;
	wire signed [WIDTH+5:0] avg_value;
	wire signed [WIDTH+5:0] held_ext;
	wire signed [WIDTH+5:0] old_ext;

	function [5:0] window_of;
		input [2:0] code;
		begin
			case (code)
			3'h1: window_of = 6'h04;
			3'h2: window_of = 6'h08;
			3'h3: window_of = 6'h10;
			3'h4: window_of = 6'h20;
			default: window_of = 6'h01;
			endcase
		end
	endfunction

	function current_bad;
		input signed [15:0] ua;
		input live_zero;
		begin
			current_bad = (ua > `ALMD_C_MAX_UA) ||
				(live_zero ? (ua < `ALMD_C_LIVE_ZERO_UA) : (ua < 0));
		end
	endfunction

	function volt_bad;
		input signed [15:0] mv;
		begin
			volt_bad = (mv > `ALMD_V_RANGE_MV) || (mv < -`ALMD_V_RANGE_MV);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sample interval, clamped to 1 ms .. 60 s
	assign interval = (INTERVAL_MS < `ALMD_INTERVAL_MS_MIN) ? 16'h0001 :
		(INTERVAL_MS > `ALMD_INTERVAL_MS_MAX) ? 16'hEA60 : INTERVAL_MS;
	assign ms_tick = (tick_count == CYC_PER_MS - 1);

	always @(posedge CLK_SYS) begin
		if (!RESETN) begin
			tick_count <= 32'h00000000;
			ms_count <= 16'h0000;
		end else begin
			tick_count <= ms_tick ? 32'h00000000 : tick_count + 32'h00000001;
			if (ms_tick) begin
				ms_count <= (ms_count + 16'h0001 >= interval) ? 16'h0000 : ms_count + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Moving average over the last N samples; history cleared on filter change
	assign win_len = window_of(FILTER_SEL);
	assign old_addr = wr_ptr - win_len[4:0];
	// Sign extended up front so the sum never mixes widths
	assign held_ext = {{6{held_sample[WIDTH-1]}}, held_sample};
	assign old_ext = {{6{old_sample[WIDTH-1]}}, old_sample};
	assign next_acc = (fill_count >= win_len) ?
		acc + held_ext - old_ext : acc + held_ext;
	assign avg_value = (FILTER_SEL == 3'h4) ? (next_acc >>> 5) :
		(FILTER_SEL == 3'h3) ? (next_acc >>> 4) :
		(FILTER_SEL == 3'h2) ? (next_acc >>> 3) :
		(FILTER_SEL == 3'h1) ? (next_acc >>> 2) : next_acc;

	almd_hist #(.WIDTH(WIDTH), .DEPTH_LOG2(5)) u_hist (
		.clk(CLK_SYS),
		.wr_en(state == ST_EVAL),
		.wr_addr(wr_ptr),
		.wr_data(held_sample),
		.rd_addr(old_addr),
		.rd_data(old_sample)
	);

	reg [2:0] last_filter;

	always @(posedge CLK_SYS) begin
		if (!RESETN) begin
			state <= ST_IDLE;
			wr_ptr <= 5'h00;
			fill_count <= 6'h00;
			acc <= {(WIDTH+6){1'b0}};
			held_sample <= {WIDTH{1'b0}};
			eval_value <= {WIDTH{1'b0}};
			last_filter <= 3'h0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (ms_tick && (ms_count + 16'h0001 >= interval)) begin
					held_sample <= SAMPLE_VALUE;
					state <= ST_READ;
				end
			end
			ST_READ: state <= ST_EVAL;
			ST_EVAL: begin
				if (FILTER_SEL != last_filter || FILTER_SEL == 3'h0 || FILTER_SEL > 3'h4) begin
					acc <= held_ext;
					fill_count <= 6'h01;
					eval_value <= held_sample;
				end else begin
					acc <= next_acc;
					if (fill_count < win_len) begin
						fill_count <= fill_count + 6'h01;
					end
					eval_value <= (fill_count >= win_len) ? avg_value[WIDTH-1:0] : held_sample;
				end
				// Remembered per evaluation, so a change between samples still restarts
				last_filter <= FILTER_SEL;
				wr_ptr <= wr_ptr + 5'h01;
				state <= ST_DONE;
			end
			ST_DONE: state <= ST_IDLE;
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Limit supervision with release hysteresis, evaluated once per sample
	// Two guard bits so limit plus or minus margin cannot wrap
	wire signed [17:0] low_release;
	wire signed [17:0] high_release;

	assign low_release = {{2{LOW_LIMIT[15]}}, LOW_LIMIT} + {3'b000, LOW_RELEASE_MARGIN};
	assign high_release = {{2{HIGH_LIMIT[15]}}, HIGH_LIMIT} - {3'b000, HIGH_RELEASE_MARGIN};

	always @(posedge CLK_SYS) begin
		if (!RESETN) begin
			low_state <= 1'b0;
			high_state <= 1'b0;
		end else if (state == ST_DONE) begin
			if (eval_value < LOW_LIMIT) begin
				low_state <= 1'b1;
			end else if (eval_value > low_release) begin
				low_state <= 1'b0;
			end
			if (eval_value > HIGH_LIMIT) begin
				high_state <= 1'b1;
			end else if (eval_value < high_release) begin
				high_state <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Condition word; limit bits of other channels arrive from their blocks
	always @* begin
		next_status = 16'h0000;
		next_status[`ALMD_B_V1_HIGH] = OTHER_LIMIT_BITS[0];
		next_status[`ALMD_B_V1_LOW] = OTHER_LIMIT_BITS[1];
		next_status[`ALMD_B_V2_HIGH] = OTHER_LIMIT_BITS[2];
		next_status[`ALMD_B_V2_LOW] = OTHER_LIMIT_BITS[3];
		next_status[`ALMD_B_C1_HIGH] = OTHER_LIMIT_BITS[4];
		next_status[`ALMD_B_C1_LOW] = OTHER_LIMIT_BITS[5];
		next_status[`ALMD_B_C2_HIGH] = OTHER_LIMIT_BITS[6];
		next_status[`ALMD_B_C2_LOW] = OTHER_LIMIT_BITS[7];
		case (CHANNEL_ID)
		`ALMD_SRC_V1: begin
			next_status[`ALMD_B_V1_HIGH] = high_state;
			next_status[`ALMD_B_V1_LOW] = low_state;
		end
		`ALMD_SRC_V2: begin
			next_status[`ALMD_B_V2_HIGH] = high_state;
			next_status[`ALMD_B_V2_LOW] = low_state;
		end
		`ALMD_SRC_C1: begin
			next_status[`ALMD_B_C1_HIGH] = high_state;
			next_status[`ALMD_B_C1_LOW] = low_state;
		end
		default: begin
			next_status[`ALMD_B_C2_HIGH] = high_state;
			next_status[`ALMD_B_C2_LOW] = low_state;
		end
		endcase
		next_status[`ALMD_B_UNDERVOLT] = (SUPPLY_MV < `ALMD_SUPPLY_MIN_MV);
		next_status[`ALMD_B_V1_RANGE] = volt_bad(VOLT_ONE_MV);
		next_status[`ALMD_B_V2_RANGE] = volt_bad(VOLT_TWO_MV);
		next_status[`ALMD_B_C1_RANGE] = current_bad(CURR_ONE_UA, LIVE_ZERO_CFG[0]);
		next_status[`ALMD_B_C2_RANGE] = current_bad(CURR_TWO_UA, LIVE_ZERO_CFG[1]);
		next_status[`ALMD_B_C1_BREAK] = LIVE_ZERO_CFG[0] &&
			(CURR_ONE_UA < `ALMD_C_BREAK_UA);
		next_status[`ALMD_B_C2_BREAK] = LIVE_ZERO_CFG[1] &&
			(CURR_TWO_UA < `ALMD_C_BREAK_UA);
	end

	////////////////////////////////////////////////////////////////////////
	// Mask register, status, outputs and events
	wire [15:0] rose = next_status & ~prev_status & EVENT_MASK;
	wire [15:0] fell = ~next_status & prev_status & EVENT_MASK;

	always @(posedge CLK_SYS) begin
		if (!RESETN) begin
			EVENT_MASK <= `ALMD_MASK_RESET;
			STATUS_WORD <= 16'h0000;
			prev_status <= 16'h0000;
			PD_BYTE9 <= 8'h00;
			PD_BYTE10 <= 8'h00;
			SWITCH_OUT1 <= 1'b0;
			SWITCH_OUT2 <= 1'b0;
			EVENT_APPEAR <= 1'b0;
			EVENT_DISAPPEAR <= 1'b0;
			EVENT_BITS <= 16'h0000;
			SAMPLE_DONE <= 1'b0;
		end else begin
			if (MASK_WR) begin
				EVENT_MASK <= MASK_WDATA & `ALMD_MASK_WRITABLE;
			end
			STATUS_WORD <= next_status;
			prev_status <= next_status;
			PD_BYTE9 <= next_status[15:8];
			PD_BYTE10 <= next_status[7:0];
			SWITCH_OUT1 <= (REF_SOURCE == CHANNEL_ID) && low_state;
			SWITCH_OUT2 <= (REF_SOURCE == CHANNEL_ID) && high_state;
			EVENT_APPEAR <= |rose;
			EVENT_DISAPPEAR <= |fell;
			EVENT_BITS <= rose | fell;
			SAMPLE_DONE <= (state == ST_DONE);
		end
	end
endmodule // almd_top

// ### dv/almd_chk_assertions.sv
// Checker for the limit monitor top, bound to every instance of it.
// Assumes a sample interval of at least four clocks.
`timescale 1ns/10ps
module almd_chk #(
	parameter CYC_PER_MS = 40000
) (
	input wire CLK_SYS,
	input wire RESETN,
	input wire MASK_WR,
	input wire [15:0] MASK_WDATA,
	input wire [15:0] EVENT_MASK,
	input wire [15:0] STATUS_WORD,
	input wire [7:0] PD_BYTE9,
	input wire [7:0] PD_BYTE10,
	input wire SWITCH_OUT1,
	input wire SWITCH_OUT2,
	input wire EVENT_APPEAR,
	input wire EVENT_DISAPPEAR,
	input wire [15:0] EVENT_BITS,
	input wire SAMPLE_DONE,
	input wire [1:0] CHANNEL_ID,
	input wire [15:0] SUPPLY_MV
);
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (!RESETN);
////////////////////////////////////////////////////////////////////////
property p_mask; MASK_WR |=> EVENT_MASK == ($past(MASK_WDATA) & 16'h7FFF); endproperty
a_mask: assert property (p_mask) else $error("mask write wrong");
property p_pd; {PD_BYTE9, PD_BYTE10} == STATUS_WORD
	|| {PD_BYTE9, PD_BYTE10} == $past(STATUS_WORD); endproperty
a_pd: assert property (p_pd) else $error("process data bytes wrong");
// Events leave with the status change; the mask seen is the one before it
property p_appear; EVENT_APPEAR |->
	(EVENT_BITS & STATUS_WORD & ~$past(STATUS_WORD)) != 16'h0000
	&& EVENT_BITS == ((STATUS_WORD ^ $past(STATUS_WORD)) & $past(EVENT_MASK)); endproperty
a_appear: assert property (p_appear) else $error("appear event wrong");
property p_disappear; EVENT_DISAPPEAR |->
	(EVENT_BITS & ~STATUS_WORD & $past(STATUS_WORD)) != 16'h0000
	&& EVENT_BITS == ((STATUS_WORD ^ $past(STATUS_WORD)) & $past(EVENT_MASK)); endproperty
a_disappear: assert property (p_disappear) else $error("disappear event wrong");
property p_supply; $stable(SUPPLY_MV) [*4] |-> STATUS_WORD[8] == (SUPPLY_MV < 16'h4268);
endproperty
a_supply: assert property (p_supply) else $error("undervoltage bit wrong");
property p_sw1; $rose(SWITCH_OUT1) |-> STATUS_WORD[{CHANNEL_ID, 1'b1}]; endproperty
a_sw1: assert property (p_sw1) else $error("output 1 without low bit");
property p_sw2; $rose(SWITCH_OUT2) |-> STATUS_WORD[{CHANNEL_ID, 1'b0}]; endproperty
a_sw2: assert property (p_sw2) else $error("output 2 without high bit");
// Outputs follow the evaluation one cycle after the done pulse
property p_hold; $changed(SWITCH_OUT1) || $changed(SWITCH_OUT2) |-> $past(SAMPLE_DONE);
endproperty
a_hold: assert property (p_hold) else $error("output moved between samples");
property p_done; SAMPLE_DONE |=> !SAMPLE_DONE [*3]; endproperty
a_done: assert property (p_done) else $error("samples too close");
c_appear: cover property (EVENT_APPEAR);
c_disappear: cover property (EVENT_DISAPPEAR);
c_sw1: cover property ($rose(SWITCH_OUT1));
endmodule // almd_chk
bind almd_top almd_chk #(.CYC_PER_MS(CYC_PER_MS)) almd_chk_i (.*);

// ### dv/almd_link_master.sv
// Link master model: rebuilds the condition word and counts events.
// Assumes bytes and event pulses synchronous to the system clock.
`timescale 1ns/10ps
module almd_link_master (
	input wire clk,
	input wire resetn,
	input wire [7:0] pd_byte9,
	input wire [7:0] pd_byte10,
	input wire ev_appear,
	input wire ev_disappear,
	output reg [15:0] status,
	output reg [7:0] n_appear,
	output reg [7:0] n_disappear
);
always @(posedge clk) begin
	if (!resetn) begin
		status <= 16'h0000;
		n_appear <= 8'h00;
		n_disappear <= 8'h00;
	end else begin
		status <= {pd_byte9, pd_byte10};
		n_appear <= n_appear + {7'h00, ev_appear};
		n_disappear <= n_disappear + {7'h00, ev_disappear};
	end
end
endmodule // almd_link_master

// ### dv/tb_top.sv
// Bench for the limit monitor with a link master model beside it.
// Assumes a shortened millisecond of four clocks.
`timescale 1ns/10ps
`include "almd_regs.vh"
`define CHK(n, e, g) n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s exp %h got %h", n, e, g); end
module tb_top;
localparam CPM = 4;
logic CLK_SYS = 0, RESETN = 0, MASK_WR = 0;
logic signed [15:0] SAMPLE_VALUE = 0, LOW_LIMIT = `ALMD_LOW_DEFAULT;
logic signed [15:0] HIGH_LIMIT = `ALMD_HIGH_DEFAULT, VOLT_ONE_MV = 0, VOLT_TWO_MV = 0;
logic signed [15:0] CURR_ONE_UA = 16'h2710, CURR_TWO_UA = 16'h2710;
logic [15:0] INTERVAL_MS = 16'h0001, SUPPLY_MV = 16'h5DC0, MASK_WDATA = 0;
logic [14:0] LOW_RELEASE_MARGIN = 15'h000F, HIGH_RELEASE_MARGIN = 15'h000F;
logic [2:0] FILTER_SEL = 0;
logic [1:0] REF_SOURCE = 0, CHANNEL_ID = 0, LIVE_ZERO_CFG = 0;
logic [7:0] OTHER_LIMIT_BITS = 0, PD_BYTE9, PD_BYTE10, n_app, n_dis;
logic [15:0] EVENT_MASK, STATUS_WORD, EVENT_BITS, pd_word;
logic SWITCH_OUT1, SWITCH_OUT2, EVENT_APPEAR, EVENT_DISAPPEAR, SAMPLE_DONE;
int n_errors = 0, n_compared = 0, cyc = 0, t_last = 0, t_prev = 0;
almd_top #(.CYC_PER_MS(CPM)) almd_top_i (.*);
almd_link_master almd_link_master_i (.clk(CLK_SYS), .resetn(RESETN), .pd_byte9(PD_BYTE9),
	.pd_byte10(PD_BYTE10), .ev_appear(EVENT_APPEAR), .ev_disappear(EVENT_DISAPPEAR),
	.status(pd_word), .n_appear(n_app), .n_disappear(n_dis));
initial forever #12.5 CLK_SYS = ~CLK_SYS;
// Ceiling well above the longest filter fill
always @(posedge CLK_SYS) begin
	cyc++;
	if (SAMPLE_DONE === 1'b1) begin
		t_prev = t_last;
		t_last = cyc;
	end
	if (cyc == 20000) begin
		n_errors++;
		print_verdict();
	end
end
////////////////////////////////////////////////////////////////////////
task automatic print_verdict;
	$display("compared %0d errors %0d", n_compared, n_errors);
	if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
// Waits n evaluations, then lets events and the master settle
task automatic wait_done(input int n);
	int k;
	repeat (n) begin
		k = 0;
		@(negedge CLK_SYS);
		while (SAMPLE_DONE !== 1'b1 && k < 1000) begin
			k++;
			@(negedge CLK_SYS);
		end
	end
	repeat (2) @(negedge CLK_SYS);
endtask
// One stale sample may still be in flight, hence two evaluations
task automatic samp(input logic signed [15:0] v);
	SAMPLE_VALUE = v;
	wait_done(2);
endtask
task automatic wr_mask(input logic [15:0] d);
	MASK_WDATA = d;
	MASK_WR = 1'b1;
	@(negedge CLK_SYS);
	MASK_WR = 1'b0;
	@(negedge CLK_SYS);
	`CHK("mask", d & `ALMD_MASK_WRITABLE, EVENT_MASK)
endtask
task automatic chk_lim(input logic st, input logic sw, input int bi, input logic [7:0] ea,
	input logic [7:0] ed);
	`CHK("status_bit", st, STATUS_WORD[bi])
	`CHK("switch", sw, (bi == 0) ? SWITCH_OUT2 : SWITCH_OUT1)
	`CHK("n_appear", ea, n_app)
	`CHK("n_disappear", ed, n_dis)
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	repeat (16) @(negedge CLK_SYS);
	RESETN = 1'b1;
	@(negedge CLK_SYS);
	`CHK("mask_reset", `ALMD_MASK_RESET, EVENT_MASK)
	wr_mask(16'hFFFF);
	wr_mask(16'h0002);
	$display("test mask done");
	samp(16'h7D00);
	chk_lim(1'b1, 1'b1, 0, 8'h00, 8'h00);
	samp(16'h79E0);
	chk_lim(1'b1, 1'b1, 0, 8'h00, 8'h00);
	samp(16'h79DB);
	chk_lim(1'b0, 1'b0, 0, 8'h00, 8'h00);
	samp(16'hFFFF);
	chk_lim(1'b1, 1'b1, 1, 8'h01, 8'h00);
	samp(16'h000F);
	chk_lim(1'b1, 1'b1, 1, 8'h01, 8'h00);
	samp(16'h0010);
	chk_lim(1'b0, 1'b0, 1, 8'h01, 8'h01);
	REF_SOURCE = `ALMD_SRC_V2;
	samp(16'hFFFF);
	chk_lim(1'b1, 1'b0, 1, 8'h02, 8'h01);
	samp(16'h0010);
	REF_SOURCE = `ALMD_SRC_V1;
	CHANNEL_ID = `ALMD_SRC_C2;
	REF_SOURCE = `ALMD_SRC_C2;
	samp(16'hFFFF);
	chk_lim(1'b1, 1'b1, 7, 8'h02, 8'h02);
	samp(16'h0010);
	CHANNEL_ID = `ALMD_SRC_V1;
	REF_SOURCE = `ALMD_SRC_V1;
	$display("test limits done");
	INTERVAL_MS = 16'h0003;
	wait_done(3);
	`CHK("interval", 3 * CPM, t_last - t_prev)
	INTERVAL_MS = 16'h0001;
	$display("test interval done");
	for (int f = 1; f <= 4; f++) begin
		FILTER_SEL = f[2:0];
		SAMPLE_VALUE = 16'h0000;
		wait_done((2 << f) + 3);
		SAMPLE_VALUE = 16'h7D00;
		wait_done(2);
		`CHK("avg_partial", 1'b0, STATUS_WORD[0])
		wait_done((2 << f) + 2);
		`CHK("avg_full", 1'b1, STATUS_WORD[0])
		FILTER_SEL = 3'h0;
		samp(16'h0000);
	end
	$display("test filter done");
	SUPPLY_MV = 16'h4267;
	VOLT_ONE_MV = 16'h2711;
	VOLT_TWO_MV = 16'hD8EF;
	CURR_ONE_UA = 16'h0F9F;
	CURR_TWO_UA = 16'h07CF;
	LIVE_ZERO_CFG = 2'h3;
	OTHER_LIMIT_BITS = 8'hC0;
	repeat (6) @(negedge CLK_SYS);
	`CHK("status_diag", 16'h5FC0, STATUS_WORD)
	`CHK("pd_diag", 16'h5FC0, pd_word)
	LIVE_ZERO_CFG = 2'h0;
	CURR_ONE_UA = 16'h4E21;
	repeat (6) @(negedge CLK_SYS);
	`CHK("status_zero", 16'h0FC0, STATUS_WORD)
	`CHK("n_appear_masked", 8'h02, n_app)
	$display("test diag done");
	print_verdict();
end
endmodule // tb_top
